// ==== logic/reference_frequency_select.sv ====
// reference frequency selection, command loss fallback and jump bands
//
// Behaviour
// - save mode 0: keypad reference saved at power-off, restored at power-on
// - save mode 1: saved only on save key; power-on restores last saved
// - analog drop below 10% within 400 ms declares loss; run ref times ratio
// - loss clears when analog level exceeds recovery threshold
// - ratio 999: flag loss but keep following analog command
// - recovery threshold f1*0.2 for ratio 0/999, f1*1 for 100% and above
// - analog level sampled at fixed interval; pre-loss sample kept as f1
// - loss detection uses unfiltered analog command
// - rising into band holds at lower edge until above upper edge
// - falling into band holds at upper edge until below lower edge
// - overlapping bands merge into one lowest-to-highest band
// - jump centres 0.0 to 120.0 hz, 0.0 gives no band
// - band width 0.0 to 30.0 hz, 0.0 disables all bands
// - step select bits form code n; nonzero n picks preset n
// - presets accept 0.00 to 120.00 hz
// - code zero uses the analog command when active, else primary or secondary command source
// - pid: bits 3,2 pick process source or pid presets one to three
// - pid cancelled: bits 1,0 pick non-preset source or presets one to three
// - pid presets are in pid display units
`timescale 1ns/100ps
`default_nettype none
module reference_frequency_select
   import ref_sel_pkg::*;
#(
   parameter int LOSS_CYC = LOSS_WINDOW_CYC,
   parameter int SAMPLE_CYC = LOSS_WINDOW_CYC / 8
)
(
   input  wire logic                sys_clk,
   input  wire logic                nrst,
   input  wire logic                ref_save_mode,
   input  wire logic                save_key,
   input  wire logic                power_fail,
   input  wire logic [FREQ_W-1:0]   keypad_ref,
   input  wire logic [FREQ_W-1:0]   analog_cmd,
   input  wire logic                analog_active,
   input  wire logic [9:0]          loss_fallback_ratio,
   input  wire logic [FREQ_W-1:0]   primary_freq_source,
   input  wire logic [FREQ_W-1:0]   secondary_freq_source,
   input  wire logic                use_secondary,
   input  wire logic [FREQ_W-1:0]   pid_process_source,
   input  wire logic [1:0]          pid_mode_select,
   input  wire logic [2:0]          pid_display_units,
   input  wire logic                pid_cancel_input,
   input  wire logic                step_sel_bit0,
   input  wire logic                step_sel_bit1,
   input  wire logic                step_sel_bit2,
   input  wire logic                step_sel_bit3,
   input  wire logic [FREQ_W*NUM_PRESETS-1:0] preset_freq,
   input  wire logic [FREQ_W-1:0]   pid_preset_1,
   input  wire logic [FREQ_W-1:0]   pid_preset_2,
   input  wire logic [FREQ_W-1:0]   pid_preset_3,
   input  wire logic [FREQ_W-1:0]   jump_center_1,
   input  wire logic [FREQ_W-1:0]   jump_center_2,
   input  wire logic [FREQ_W-1:0]   jump_center_3,
   input  wire logic [FREQ_W-1:0]   jump_band_width,
   output logic      [FREQ_W-1:0]   stored_ref,
   output logic      [FREQ_W-1:0]   freq_ref,
   output logic      [FREQ_W-1:0]   process_cmd,
   output logic      [2:0]          process_units,
   output logic                     cmd_loss
);
   initial begin
      if (LOSS_CYC < 2 || SAMPLE_CYC < 1 || SAMPLE_CYC > LOSS_CYC)
         $error("bad loss timing parameters");
   end

   typedef enum logic [2:0] {
      ST_FOLLOW = 3'b001,
      ST_LOST   = 3'b010,
      ST_HOLD   = 3'b100
   } loss_st_t;

   step_sel_t sel;
   assign sel.code = {step_sel_bit3, step_sel_bit2, step_sel_bit1,
                      step_sel_bit0};
   assign sel.pid_enable = (pid_mode_select != 2'h0);
   assign sel.pid_cancel = pid_cancel_input;

   // nonvolatile keypad reference store
   logic [FREQ_W-1:0] store_reg;
   logic              pf_d_reg;
   wire               pf_edge = power_fail && !pf_d_reg;
   wire               save_auto = (ref_save_mode == SAVE_AUTO) && pf_edge;
   wire               save_man = (ref_save_mode == SAVE_KEY) && save_key;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         store_reg <= '0;
         pf_d_reg <= 1'b0;
      end else begin
         pf_d_reg <= power_fail;
         if (save_auto || save_man)
            store_reg <= keypad_ref;
      end
   end

   // command loss detection on the raw analog command
   logic [31:0]       samp_cnt_reg;
   logic [31:0]       win_cnt_reg;
   logic [FREQ_W-1:0] f1_reg;
   loss_st_t          st_reg;
   loss_st_t          st_next;
   wire               samp_tick = (samp_cnt_reg == 32'(SAMPLE_CYC - 1));
   wire [22:0]        lvl_x100 = 23'(analog_cmd) * 23'(PCT_FULL);
   wire [22:0]        f1_x10 = 23'(f1_reg) * 23'(LOSS_PCT);
   wire [22:0]        f1_x20 = 23'(f1_reg) * 23'(RECOVER_PCT);
   wire [22:0]        f1_x100 = 23'(f1_reg) * 23'(PCT_FULL);
   wire               below_loss = lvl_x100 < f1_x10;
   wire               full_thr = (loss_fallback_ratio >= RATIO_FULL) &&
                                 (loss_fallback_ratio != RATIO_DISABLED);
   wire [22:0]        recov_thr = full_thr ? f1_x100 : f1_x20;
   wire               above_recov = lvl_x100 > recov_thr;
   wire               in_window = win_cnt_reg < 32'(LOSS_CYC);

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ST_FOLLOW: if (analog_active && below_loss && in_window &&
                        f1_reg != '0)
            st_next = ST_LOST;
         ST_LOST: if (above_recov)
            st_next = ST_FOLLOW;
         ST_HOLD: st_next = ST_FOLLOW;
         default: st_next = ST_FOLLOW;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         samp_cnt_reg <= '0;
         win_cnt_reg <= '0;
         f1_reg <= '0;
         st_reg <= ST_FOLLOW;
      end else begin
         st_reg <= st_next;
         samp_cnt_reg <= samp_tick ? '0 : samp_cnt_reg + 32'h1;
         // no sample on the edge that declares loss: f1 stays pre-loss
         if (samp_tick && st_reg == ST_FOLLOW && st_next == ST_FOLLOW) begin
            f1_reg <= analog_cmd;
            win_cnt_reg <= '0;
         end else if (in_window)
            win_cnt_reg <= win_cnt_reg + 32'h1;
      end
   end

   wire lost = (st_reg == ST_LOST);

   // preset selection
   logic [FREQ_W-1:0] preset [NUM_PRESETS+1];
   assign preset[0] = '0;
   genvar g;
   generate
      for (g = 0; g < NUM_PRESETS; g++) begin : g_pre
         assign preset[g+1] = (preset_freq[g*FREQ_W +: FREQ_W] > FREQ_MAX) ?
            FREQ_MAX : preset_freq[g*FREQ_W +: FREQ_W];
      end
   endgenerate

   wire [FREQ_W-1:0] base_src = use_secondary ? secondary_freq_source
                                              : primary_freq_source;
   wire [FREQ_W-1:0] nonpreset = analog_active ? analog_cmd : base_src;
   wire [1:0]        man_code = sel.code[1:0];
   wire [1:0]        pid_code = sel.code[3:2];
   wire              pid_man = sel.pid_enable && sel.pid_cancel;
   wire [FREQ_W-1:0] sel_ref = pid_man ?
      ((man_code == 2'h0) ? nonpreset : preset[man_code]) :
      ((sel.code == 4'h0) ? nonpreset : preset[sel.code]);

   wire              use_np = pid_man ? (man_code == 2'h0) :
                                        (sel.code == 4'h0);
   // a broken analog wire reads low: scale the last good sample instead
   wire [FREQ_W-1:0] fb_src = (use_np && analog_active) ? f1_reg
                                                        : sel_ref;
   wire [FREQ_W+9:0] scaled = (FREQ_W+10)'(fb_src) *
                              (FREQ_W+10)'(loss_fallback_ratio);
   wire [FREQ_W+9:0] fb_raw = scaled / (FREQ_W+10)'(PCT_FULL);
   wire [FREQ_W-1:0] fallback = (fb_raw > (FREQ_W+10)'(FREQ_MAX)) ?
                                FREQ_MAX : fb_raw[FREQ_W-1:0];
   wire use_fb = lost && !analog_active ? 1'b0 :
                 lost && loss_fallback_ratio != RATIO_DISABLED;
   wire [FREQ_W-1:0] pre_jump = use_fb ? fallback : sel_ref;

   wire [FREQ_W-1:0] proc_next =
      (pid_code == 2'h0) ? pid_process_source :
      (pid_code == 2'h1) ? pid_preset_1 :
      (pid_code == 2'h2) ? pid_preset_2 : pid_preset_3;

   logic [FREQ_W-1:0] jumped;
   jump_band_filter u_jump (
      .sys_clk         (sys_clk),
      .nrst            (nrst),
      .ref_in          (pre_jump),
      .jump_center_1   (jump_center_1),
      .jump_center_2   (jump_center_2),
      .jump_center_3   (jump_center_3),
      .jump_band_width (jump_band_width),
      .ref_out         (jumped)
   );

   logic [FREQ_W-1:0] freq_reg;
   logic [FREQ_W-1:0] proc_reg;
   logic [2:0]        units_reg;
   logic              loss_reg;
   logic [FREQ_W-1:0] stored_out_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         freq_reg <= '0;
         proc_reg <= '0;
         units_reg <= '0;
         loss_reg <= 1'b0;
         stored_out_reg <= '0;
      end else begin
         freq_reg <= jumped;
         proc_reg <= sel.pid_enable ? proc_next : '0;
         units_reg <= pid_display_units;
         loss_reg <= lost;
         stored_out_reg <= store_reg;
      end
   end

   assign freq_ref = freq_reg;
   assign process_cmd = proc_reg;
   assign process_units = units_reg;
   assign cmd_loss = loss_reg;
   assign stored_ref = stored_out_reg;

   a_auto_save: assert property (@(posedge sys_clk) disable iff (!nrst)
      save_auto |=> store_reg == $past(keypad_ref))
      else $error("auto save missed");
   a_key_only_save: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ref_save_mode == SAVE_KEY && !save_key) |=> $stable(store_reg))
      else $error("store changed without key");
   a_loss_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_reg == ST_FOLLOW && st_next == ST_LOST) |=> ##1 cmd_loss)
      else $error("loss flag late");
   a_recover_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
      (lost && above_recov) |=> ##1 !cmd_loss)
      else $error("loss not cleared");
   a_disabled_ratio: assert property (@(posedge sys_clk) disable iff (!nrst)
      (loss_fallback_ratio == RATIO_DISABLED) |-> pre_jump == sel_ref)
      else $error("ratio 999 changed ref");
   a_recov_thr: assert property (@(posedge sys_clk) disable iff (!nrst)
      (loss_fallback_ratio == RATIO_ZERO) |-> recov_thr == f1_x20)
      else $error("recovery threshold wrong");
   a_f1_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      lost |=> $stable(f1_reg))
      else $error("f1 moved during loss");
   a_preset_pick: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!pid_man && sel.code == 4'h5 && !use_fb) |-> sel_ref == preset[5])
      else $error("preset select wrong");
   a_pid_proc: assert property (@(posedge sys_clk) disable iff (!nrst)
      (sel.pid_enable && pid_code == 2'h2) |=> process_cmd == $past(pid_preset_2))
      else $error("pid preset wrong");
endmodule
`default_nettype wire

// ==== logic/ref_sel_pkg.sv ====
// shared constants and carriers for reference frequency selection
package ref_sel_pkg;
   localparam int FREQ_W = 16;          // 0.01 hz units
   localparam int NUM_PRESETS = 15;
   localparam int NUM_JUMPS = 3;
   localparam logic [15:0] FREQ_MAX = 16'h2ee0;       // 120.00 hz
   localparam logic [15:0] BAND_MAX = 16'h0bb8;       // 30.00 hz
   localparam logic [9:0] RATIO_DISABLED = 10'h3e7;   // 999
   localparam logic [9:0] RATIO_FULL = 10'h064;       // 100 %
   localparam logic [9:0] RATIO_ZERO = 10'h000;
   localparam logic [6:0] LOSS_PCT = 7'h0a;           // 10 %
   localparam logic [6:0] RECOVER_PCT = 7'h14;        // 0.2
   localparam logic [6:0] PCT_FULL = 7'h64;
   localparam int CLK_MHZ = 250;
   localparam int LOSS_WINDOW_MS = 400;
   localparam int LOSS_WINDOW_CYC = LOSS_WINDOW_MS * 1000 * CLK_MHZ;
   localparam logic SAVE_AUTO = 1'b0;
   localparam logic SAVE_KEY = 1'b1;

   typedef struct packed {
      logic [3:0] code;
      logic       pid_enable;
      logic       pid_cancel;
   } step_sel_t;

   typedef struct packed {
      logic [15:0] lo;
      logic [15:0] hi;
      logic        valid;
   } band_t;
endpackage

// ==== logic/jump_band_filter.sv ====
// jump band skip filter for the reference frequency
`timescale 1ns/100ps
`default_nettype none
module jump_band_filter
   import ref_sel_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   input  wire logic [FREQ_W-1:0]  ref_in,
   input  wire logic [FREQ_W-1:0]  jump_center_1,
   input  wire logic [FREQ_W-1:0]  jump_center_2,
   input  wire logic [FREQ_W-1:0]  jump_center_3,
   input  wire logic [FREQ_W-1:0]  jump_band_width,
   output logic      [FREQ_W-1:0]  ref_out
);
   logic [FREQ_W-1:0] ctr [NUM_JUMPS];
   band_t             raw [NUM_JUMPS];
   band_t             mrg [NUM_JUMPS];
   logic [FREQ_W-1:0] half_w;
   logic [FREQ_W-1:0] out_reg;
   logic [FREQ_W-1:0] out_next;
   logic [FREQ_W-1:0] prev_reg;

   assign ctr[0] = jump_center_1;
   assign ctr[1] = jump_center_2;
   assign ctr[2] = jump_center_3;
   assign half_w = jump_band_width >> 1;

   genvar g;
   generate
      for (g = 0; g < NUM_JUMPS; g++) begin : g_band
         // band centred on its jump frequency, half width each side
         assign raw[g].lo = (ctr[g] > half_w) ? ctr[g] - half_w : '0;
         assign raw[g].hi = ctr[g] + half_w;
         assign raw[g].valid = (ctr[g] != '0) && (jump_band_width != '0)
            && (ctr[g] <= FREQ_MAX) && (jump_band_width <= BAND_MAX);
      end
   endgenerate

   // overlapping bands grow into one; two passes cover a chain of three
   always_comb begin
      band_t t [NUM_JUMPS];
      for (int i = 0; i < NUM_JUMPS; i++) t[i] = raw[i];
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < NUM_JUMPS; i++)
            for (int j = 0; j < NUM_JUMPS; j++)
               if (t[i].valid && t[j].valid && t[i].lo <= t[j].hi
                   && t[j].lo <= t[i].hi) begin
                  if (t[j].lo < t[i].lo) t[i].lo = t[j].lo;
                  if (t[j].hi > t[i].hi) t[i].hi = t[j].hi;
               end
      for (int i = 0; i < NUM_JUMPS; i++) mrg[i] = t[i];
   end

   always_comb begin
      out_next = ref_in;
      for (int i = 0; i < NUM_JUMPS; i++)
         if (mrg[i].valid && ref_in > mrg[i].lo && ref_in < mrg[i].hi) begin
            if (prev_reg <= mrg[i].lo)
               out_next = mrg[i].lo;
            else if (prev_reg >= mrg[i].hi)
               out_next = mrg[i].hi;
            else
               out_next = out_reg;
         end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         out_reg <= '0;
         prev_reg <= '0;
      end else begin
         out_reg <= out_next;
         prev_reg <= out_next;
      end
   end
   assign ref_out = out_reg;
endmodule
`default_nettype wire

// ==== verif/ref_partner.sv ====
// keypad, analog command and step-select terminals facing the selector
`timescale 1ns/100ps
`default_nettype none
module ref_partner
   import ref_sel_pkg::*;
(
   input  wire logic              sys_clk,
   output logic                   step_sel_bit0,
   output logic                   step_sel_bit1,
   output logic                   step_sel_bit2,
   output logic                   step_sel_bit3,
   output logic      [FREQ_W-1:0] analog_cmd,
   output logic      [FREQ_W-1:0] keypad_ref,
   output logic                   save_key,
   output logic                   power_fail
);
   initial begin
      {step_sel_bit3, step_sel_bit2, step_sel_bit1, step_sel_bit0} = 4'h0;
      analog_cmd = 16'h0000;
      keypad_ref = 16'h0000;
      save_key = 1'b0;
      power_fail = 1'b0;
   end

   // code n spread over four terminals weighted 1, 2, 4, 8
   task automatic set_code(input logic [3:0] n);
      @(posedge sys_clk);
      #1;
      {step_sel_bit3, step_sel_bit2, step_sel_bit1, step_sel_bit0} = n;
   endtask

   // steps > 0 ramps slowly; only used for rising levels
   task automatic set_analog(input logic [15:0] v, input int steps);
      logic [15:0] d;
      d = (v - analog_cmd) / 16'(steps + 1);
      for (int i = 0; i < steps; i++) begin
         @(posedge sys_clk);
         #1;
         analog_cmd = analog_cmd + d;
      end
      @(posedge sys_clk);
      #1;
      analog_cmd = v;
   endtask

   // one cycle of save key, or a power-off edge when off is set
   task automatic key_event(input logic [15:0] v, input logic off);
      @(posedge sys_clk);
      #1;
      keypad_ref = v;
      save_key = !off;
      power_fail = off;
      @(posedge sys_clk);
      #1;
      save_key = 1'b0;
      power_fail = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for reference frequency selection
`timescale 1ns/100ps
`default_nettype none
module tb_top import ref_sel_pkg::*;;
   logic                          sys_clk, nrst, ref_save_mode;
   logic                          analog_active, use_secondary, pid_cancel;
   logic [1:0]                    pid_mode;
   logic [2:0]                    pid_units;
   logic [9:0]                    ratio;
   logic [FREQ_W-1:0]             primary, secondary, jc1, jc2, jc3, jbw;
   logic [FREQ_W-1:0]             pid_v [4];
   logic [FREQ_W*NUM_PRESETS-1:0] presets;
   wire logic                     b0, b1, b2, b3, save_key, power_fail;
   wire logic                     cmd_loss;
   wire logic [FREQ_W-1:0]        analog_cmd, keypad_ref, stored_ref;
   wire logic [FREQ_W-1:0]        freq_ref, process_cmd;
   wire logic [2:0]               process_units;
   int                            mismatches, tests_run;
   logic [18:0]                   notes [$];
   event                          chk;
   logic [9:0]  l_ratio [4] = '{10'h032, 10'h3e7, 10'h064, 10'h000};
   logic [15:0] l_lost [4] = '{16'h09c4, 16'h00c8, 16'h1388, 16'h0000};
   logic        l_hold [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

   ref_partner i_ref_partner (.sys_clk(sys_clk), .step_sel_bit0(b0),
      .step_sel_bit1(b1), .step_sel_bit2(b2), .step_sel_bit3(b3),
      .analog_cmd(analog_cmd), .keypad_ref(keypad_ref),
      .save_key(save_key), .power_fail(power_fail));

   reference_frequency_select #(.LOSS_CYC(64), .SAMPLE_CYC(8))
   i_reference_frequency_select (.sys_clk(sys_clk), .nrst(nrst),
      .ref_save_mode(ref_save_mode), .save_key(save_key),
      .power_fail(power_fail), .keypad_ref(keypad_ref),
      .analog_cmd(analog_cmd), .analog_active(analog_active),
      .loss_fallback_ratio(ratio), .primary_freq_source(primary),
      .secondary_freq_source(secondary), .use_secondary(use_secondary),
      .pid_process_source(pid_v[0]), .pid_mode_select(pid_mode),
      .pid_display_units(pid_units), .pid_cancel_input(pid_cancel),
      .step_sel_bit0(b0), .step_sel_bit1(b1), .step_sel_bit2(b2),
      .step_sel_bit3(b3), .preset_freq(presets), .pid_preset_1(pid_v[1]),
      .pid_preset_2(pid_v[2]), .pid_preset_3(pid_v[3]),
      .jump_center_1(jc1), .jump_center_2(jc2), .jump_center_3(jc3),
      .jump_band_width(jbw), .stored_ref(stored_ref), .freq_ref(freq_ref),
      .process_cmd(process_cmd), .process_units(process_units),
      .cmd_loss(cmd_loss));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic expect_out(input logic [2:0] sel, input logic [15:0] v);
      notes.push_back({sel, v});
      ->chk;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic jstep(input logic [15:0] p, input logic [15:0] e);
      primary = p;
      settle(4);
      expect_out(3'h0, e);
   endtask

   task automatic close_out;
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // takes every queued note, oldest first, whenever a result is announced
   initial begin
      logic [18:0] n;
      logic [15:0] seen;
      forever begin
         @chk;
         while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n[18:16])
               3'h0: seen = freq_ref;
               3'h1: seen = process_cmd;
               3'h2: seen = stored_ref;
               3'h3: seen = {15'h0000, cmd_loss};
               default: seen = {13'h0000, process_units};
            endcase
            check(seen, n[15:0]);
         end
      end
   end

   initial begin
      #100000;
      mismatches++;
      close_out();
   end

   initial begin
      {nrst, ref_save_mode, analog_active, use_secondary, pid_cancel} = 5'h00;
      {pid_mode, pid_units, ratio} = 15'h0000;
      {primary, secondary, jc1, jc2, jc3, jbw} = 96'h0;
      void'($urandom(32'hdc9f23a1));
      for (int i = 0; i < 4; i++) pid_v[i] = 16'($urandom % 12001);
      for (int i = 0; i < 15; i++) presets[i*16 +: 16] = 16'($urandom % 12001);
      secondary = 16'($urandom % 12001);
      primary = 16'h0fa0;
      settle(3);
      expect_out(3'h0, 16'h0000);
      expect_out(3'h2, 16'h0000);
      nrst = 1'b1;
      settle(2);
      i_ref_partner.key_event(16'h04d2, 1'b1);
      settle(3);
      expect_out(3'h2, 16'h04d2);
      i_ref_partner.key_event(16'h0100, 1'b0);
      settle(3);
      expect_out(3'h2, 16'h04d2);
      ref_save_mode = 1'b1;
      i_ref_partner.key_event(16'h0200, 1'b0);
      settle(3);
      expect_out(3'h2, 16'h0200);
      i_ref_partner.key_event(16'h0300, 1'b1);
      settle(3);
      expect_out(3'h2, 16'h0200);
      for (int n = 1; n <= 15; n++) begin
         i_ref_partner.set_code(n[3:0]);
         settle(4);
         expect_out(3'h0, presets[(n-1)*16 +: 16]);
      end
      i_ref_partner.set_code(4'h0);
      settle(4);
      expect_out(3'h0, primary);
      use_secondary = 1'b1;
      settle(4);
      expect_out(3'h0, secondary);
      use_secondary = 1'b0;
      pid_mode = 2'h1;
      pid_units = 3'h5;
      for (int k = 0; k < 4; k++) begin
         i_ref_partner.set_code({k[1:0], 2'($urandom)});
         settle(4);
         expect_out(3'h1, pid_v[k]);
      end
      expect_out(3'h4, 16'h0005);
      pid_cancel = 1'b1;
      for (int m = 0; m < 4; m++) begin
         i_ref_partner.set_code({2'($urandom), m[1:0]});
         settle(4);
         if (m == 0) expect_out(3'h0, primary);
         else expect_out(3'h0, presets[(m-1)*16 +: 16]);
      end
      {pid_mode, pid_cancel} = 3'h0;
      i_ref_partner.set_code(4'h0);
      jc1 = 16'h1388;
      jbw = 16'h03e8;
      jstep(16'h0fa0, 16'h0fa0);
      jstep(16'h1388, 16'h1194);
      jstep(16'h1770, 16'h1770);
      jstep(16'h1388, 16'h157c);
      jstep(16'h0fa0, 16'h0fa0);
      jc2 = 16'h15e0;
      jstep(16'h16a8, 16'h1194);
      jstep(16'h1b58, 16'h1b58);
      jstep(16'h1450, 16'h17d4);
      {jc1, jc2} = 32'h0;
      jstep(16'h012c, 16'h012c);
      jc1 = 16'h1388;
      jbw = 16'h0000;
      jstep(16'h1388, 16'h1388);
      analog_active = 1'b1;
      for (int c = 0; c < 4; c++) begin
         ratio = l_ratio[c];
         i_ref_partner.set_analog(16'h1388, 0);
         settle(40);
         i_ref_partner.set_analog(16'h00c8, 0);
         settle(12);
         expect_out(3'h3, 16'h0001);
         expect_out(3'h0, l_lost[c]);
         i_ref_partner.set_analog(16'h0bb8, 4);
         settle(8);
         expect_out(3'h3, {15'h0000, l_hold[c]});
         expect_out(3'h0, l_hold[c] ? l_lost[c] : 16'h0bb8);
         i_ref_partner.set_analog(16'h1770, 0);
         settle(8);
         expect_out(3'h3, 16'h0000);
         expect_out(3'h0, 16'h1770);
      end
      settle(2);
      close_out();
   end
endmodule
`default_nettype wire
